//--- logic/current_loop_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: object access by 16-bit index and 8-bit sub-index
// Notes: included by bare name; definitions only
`ifndef CURRENT_LOOP_DEFINES_SVH
`define CURRENT_LOOP_DEFINES_SVH

// object indices
`define IDX_GAIN_RECORD 16'h60f6
`define IDX_TORQUE_OFFSET 16'h60b2
`define IDX_POST_OFFSET 16'h30b3
`define IDX_ACTUAL_CURRENT 16'h6078
`define IDX_FILTER_CUTOFF 16'h3078
`define IDX_LOOP_CALC 16'h3411

// sub-indices of the gain record
`define SUB_COUNT 8'h00
`define SUB_SELECTOR 8'h01
`define SUB_Q_KP 8'h02
`define SUB_Q_KI 8'h03
`define SUB_D_KP 8'h04
`define SUB_D_KI 8'h05
`define GAIN_ENTRIES 8'h05

// reset values
`define RST_SELECTOR 16'h0000
`define RST_GAIN 16'h0000
`define RST_OFFSET 16'h0000
`define RST_CUTOFF 16'h03e8
`define RST_CALC 32'h0000_0000

// signature that starts the gain calculation
`define CALC_SIGNATURE 32'h636c_6163

// timing: clock rate and filter sample rate, both in hertz
`define CLK_HZ 250000000
`define FILT_SAMPLE_HZ 16000
`define FILT_SAMPLE_DIV (`CLK_HZ / `FILT_SAMPLE_HZ)
// filter coefficient per hertz in q16: round(2*pi*65536/sample rate)
`define FILT_COEF_PER_HZ 21'h00001a
`define FILT_COEF_MAX 17'h10000

`endif

//--- logic/current_loop_pkg.sv
// Purpose: shared types of the current-loop parameter block
// Assumes: constants live in current_loop_defines.svh
// Notes: nothing here is imported; use current_loop_pkg::name
package current_loop_pkg;
   // answer given one cycle after an object access
   typedef enum logic [1:0] {
      RESP_NONE = 2'b00,
      RESP_ACK = 2'b01,
      RESP_ERR = 2'b10
   } od_resp_t;
   // signed current in thousandths of rated current
   typedef logic signed [15:0] amp_t;
endpackage

//--- logic/current_loop_parameter_block.sv
// Purpose: current-loop parameter objects, torque offsets, filtered
//          actual current
// Assumes: one object access per cycle; inputs synchronous to clk
// Notes: answers come one cycle after the access
`timescale 1ns/1ps
`include "current_loop_defines.svh"

module current_loop_parameter_block #(
   parameter int unsigned SAMPLE_DIV = `FILT_SAMPLE_DIV
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic od_wr,
   input wire logic od_rd,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_sub,
   input wire logic [31:0] od_wdata,
   output logic [31:0] od_rdata,
   output logic od_ack,
   output logic od_err,
   input wire logic [15:0] motor_inductance,
   input wire logic [15:0] motor_resistance,
   input wire logic drive_enable,
   input wire logic signed [15:0] current_cmd,
   input wire logic signed [15:0] dynamic_amp_limit,
   output logic signed [15:0] motor_current_cmd,
   input wire logic signed [15:0] measured_current,
   output logic signed [15:0] actual_current,
   output logic [15:0] loop_regulator_selector,
   output logic [15:0] q_axis_proportional_gain,
   output logic [15:0] q_axis_integral_gain,
   output logic [15:0] d_axis_proportional_gain,
   output logic [15:0] d_axis_integral_gain
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // saturate a 17-bit signed sum to 16 bits
   function automatic logic signed [15:0] sat16(
      input logic signed [16:0] v
   );
      if (v > 17'sh07fff) begin
         sat16 = 16'sh7fff;
      end else if (v < 17'sh18000) begin
         sat16 = 16'sh8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction

   // ---------------- object registers ----------------
   logic [15:0] gain [1:5]; // record entries by sub-index
   logic signed [15:0] torque_offset; // before limitation
   logic signed [15:0] post_limit_torque_offset; // after limitation
   logic signed [15:0] current_filter_cutoff; // hertz
   logic [31:0] loop_calc; // last value written to the calc object
   logic [15:0] next_gain [1:5];
   logic signed [15:0] next_torque_offset;
   logic signed [15:0] next_post_offset;
   logic signed [15:0] next_cutoff;
   logic [31:0] next_loop_calc;
   current_loop_pkg::od_resp_t next_resp; // answer to register
   logic [31:0] next_rdata;
   logic calc_go; // signature seen on the calc object

   // record entries drive the loop directly
   assign loop_regulator_selector = gain[1];
   assign q_axis_proportional_gain = gain[2];
   assign q_axis_integral_gain = gain[3];
   assign d_axis_proportional_gain = gain[4];
   assign d_axis_integral_gain = gain[5];
   assign calc_go = od_wr && (od_index == `IDX_LOOP_CALC) &&
      (od_wdata == `CALC_SIGNATURE);

   // decode object accesses; a write wins over a read in one cycle
   always_comb begin
      next_gain = gain;
      next_torque_offset = torque_offset;
      next_post_offset = post_limit_torque_offset;
      next_cutoff = current_filter_cutoff;
      next_loop_calc = loop_calc;
      next_rdata = od_rdata;
      next_resp = current_loop_pkg::RESP_NONE;
      if (od_wr) begin
         next_resp = current_loop_pkg::RESP_ACK;
         if (od_index == `IDX_GAIN_RECORD) begin
            // full 16-bit range accepted, low half of the word
            if (od_sub >= `SUB_SELECTOR && od_sub <= `SUB_D_KI) begin
               next_gain[od_sub] = od_wdata[15:0];
            end else begin
               // entry count is read-only, others unmapped
               next_resp = current_loop_pkg::RESP_ERR;
            end
         end else if (od_index == `IDX_TORQUE_OFFSET) begin
            next_torque_offset = od_wdata[15:0];
         end else if (od_index == `IDX_POST_OFFSET) begin
            next_post_offset = od_wdata[15:0];
         end else if (od_index == `IDX_FILTER_CUTOFF) begin
            next_cutoff = od_wdata[15:0];
         end else if (od_index == `IDX_LOOP_CALC) begin
            next_loop_calc = od_wdata;
            if (calc_go) begin
               // proportional from inductance, integral from resistance
               next_gain[2] = motor_inductance;
               next_gain[3] = motor_resistance;
               next_gain[4] = motor_inductance;
               next_gain[5] = motor_resistance;
            end
         end else begin
            // actual current is read-only; the rest is unmapped
            next_resp = current_loop_pkg::RESP_ERR;
         end
      end else if (od_rd) begin
         next_resp = current_loop_pkg::RESP_ACK;
         next_rdata = 32'h0000_0000;
         if (od_index == `IDX_GAIN_RECORD) begin
            if (od_sub == `SUB_COUNT) begin
               next_rdata = {24'h00_0000, `GAIN_ENTRIES};
            end else if (od_sub <= `SUB_D_KI) begin
               next_rdata = {16'h0000, gain[od_sub]};
            end else begin
               next_resp = current_loop_pkg::RESP_ERR;
            end
         end else if (od_index == `IDX_TORQUE_OFFSET) begin
            next_rdata = {{16{torque_offset[15]}}, torque_offset};
         end else if (od_index == `IDX_POST_OFFSET) begin
            next_rdata = {{16{post_limit_torque_offset[15]}},
               post_limit_torque_offset};
         end else if (od_index == `IDX_FILTER_CUTOFF) begin
            next_rdata = {{16{current_filter_cutoff[15]}},
               current_filter_cutoff};
         end else if (od_index == `IDX_ACTUAL_CURRENT) begin
            // signed thousandths of rated current
            next_rdata = {{16{actual_current[15]}},
               actual_current};
         end else if (od_index == `IDX_LOOP_CALC) begin
            next_rdata = loop_calc;
         end else begin
            next_resp = current_loop_pkg::RESP_ERR;
         end
      end
   end

   // register the object state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gain[1] <= `RST_SELECTOR;
         gain[2] <= `RST_GAIN;
         gain[3] <= `RST_GAIN;
         gain[4] <= `RST_GAIN;
         gain[5] <= `RST_GAIN;
         torque_offset <= `RST_OFFSET;
         post_limit_torque_offset <= `RST_OFFSET;
         current_filter_cutoff <= `RST_CUTOFF;
         loop_calc <= `RST_CALC;
         od_rdata <= 32'h0000_0000;
         od_ack <= 1'b0;
         od_err <= 1'b0;
      end else begin
         gain <= next_gain;
         torque_offset <= next_torque_offset;
         post_limit_torque_offset <= next_post_offset;
         current_filter_cutoff <= next_cutoff;
         loop_calc <= next_loop_calc;
         od_rdata <= next_rdata;
         // answer flags come straight from flip-flops
         od_ack <= (next_resp == current_loop_pkg::RESP_ACK);
         od_err <= (next_resp == current_loop_pkg::RESP_ERR);
      end
   end

   // ---------------- current command path ----------------
   logic signed [15:0] pre_sum; // command plus first offset
   logic signed [15:0] cmd_d; // bare command, same stage
   logic signed [15:0] next_pre_sum;
   logic signed [15:0] next_cmd_d;
   logic signed [15:0] next_out;
   logic signed [15:0] lim_pos; // dynamic limit, never negative
   logic signed [15:0] limited; // command after the limitation
   logic signed [15:0] limit_in;

   // stage 1 adds the first offset; stage 2 limits, then adds second
   always_comb begin
      lim_pos = dynamic_amp_limit[15] ? 16'sh0000 : dynamic_amp_limit;
      next_cmd_d = current_cmd;
      if (drive_enable) begin
         next_pre_sum = sat16(17'(current_cmd) +
            17'(torque_offset));
      end else begin
         next_pre_sum = current_cmd;
      end
      // a disable in stage 2 drops the offset taken in stage 1
      limit_in = drive_enable ? pre_sum : cmd_d;
      if (limit_in > lim_pos) begin
         limited = lim_pos;
      end else if (limit_in < -lim_pos) begin
         limited = -lim_pos;
      end else begin
         limited = limit_in;
      end
      if (drive_enable) begin
         // added after the clamp, so it can exceed the limit
         next_out = sat16(17'(limited) +
            17'(post_limit_torque_offset));
      end else begin
         next_out = limited;
      end
   end

   // register the command path
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pre_sum <= 16'sh0000;
         cmd_d <= 16'sh0000;
         motor_current_cmd <= 16'sh0000;
      end else begin
         pre_sum <= next_pre_sum;
         cmd_d <= next_cmd_d;
         motor_current_cmd <= next_out;
      end
   end

   // ---------------- actual current filter ----------------
   logic [15:0] tick_cnt; // sample-rate divider
   logic [15:0] next_tick_cnt;
   logic tick; // one filter update
   logic signed [31:0] filt_acc; // filter state, q16
   logic signed [31:0] next_filt_acc;
   logic [20:0] coef_raw; // cutoff times coefficient per hertz
   logic [16:0] coef; // update gain, q16, at most one
   logic signed [16:0] diff;
   logic signed [34:0] prod;
   logic signed [35:0] sum;

   // first-order low-pass at the divided sample rate
   always_comb begin
      tick = (tick_cnt == 16'(SAMPLE_DIV - 1));
      next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
      // a negative cutoff freezes the filter
      if (current_filter_cutoff[15]) begin
         coef_raw = 21'h000000;
      end else begin
         coef_raw = 21'(21'(current_filter_cutoff[14:0]) *
            `FILT_COEF_PER_HZ);
      end
      coef = (coef_raw > 21'(`FILT_COEF_MAX)) ? `FILT_COEF_MAX :
         coef_raw[16:0];
      // filter output is signed; sign-extend it before the subtraction
      diff = 17'(measured_current) - 17'($signed(filt_acc[31:16]));
      prod = 35'(diff * $signed({1'b0, coef}));
      sum = 36'(filt_acc) + 36'(prod);
      next_filt_acc = tick ? sum[31:0] : filt_acc;
   end

   // register the filter
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tick_cnt <= 16'h0000;
         filt_acc <= 32'sh0000_0000;
         actual_current <= 16'sh0000;
      end else begin
         tick_cnt <= next_tick_cnt;
         filt_acc <= next_filt_acc;
         actual_current <= next_filt_acc[31:16];
      end
   end

   // ---------------- checks ----------------
   gain_write_a: assert property (
      od_wr && od_index == `IDX_GAIN_RECORD && od_sub == `SUB_Q_KI
      |=> q_axis_integral_gain == $past(od_wdata[15:0]) && od_ack)
      else $error("gain entry write not stored");

   selector_reset_a: assert property (
      $rose(reset_n) |-> loop_regulator_selector == 16'h0000)
      else $error("selector not zero after reset");

   calc_load_a: assert property (
      calc_go |=> q_axis_proportional_gain == $past(motor_inductance)
      && d_axis_integral_gain == $past(motor_resistance))
      else $error("gain calculation did not load record");

   offset_pre_a: assert property (
      drive_enable
      |=> pre_sum == sat16(17'($past(current_cmd)) +
      17'($past(torque_offset))))
      else $error("first offset not added before limit");

   post_bypass_a: assert property (
      drive_enable && pre_sum == 16'sh0000 && !dynamic_amp_limit[15]
      |=> motor_current_cmd == sat16(17'sh00000 +
      17'($past(post_limit_torque_offset))))
      else $error("second offset was limited");

   disabled_out_a: assert property (
      !drive_enable [*2] ##0 cmd_d == 16'sh0000
      |=> motor_current_cmd == 16'sh0000)
      else $error("offset reached disabled drive");

   ro_write_a: assert property (
      od_wr && od_index == `IDX_ACTUAL_CURRENT
      // a refused access taken right behind may raise it again
      |=> od_err && !od_ack ##1 (!od_err || $past(od_wr || od_rd)))
      else $error("write to actual current not refused");

   actual_read_a: assert property (
      od_rd && !od_wr && od_index == `IDX_ACTUAL_CURRENT
      |=> od_rdata == {{16{$past(actual_current[15])}},
      $past(actual_current)})
      else $error("actual current read wrong");

   filter_hold_a: assert property (
      !tick |=> $stable(actual_current))
      else $error("filter moved between samples");

endmodule

//--- verification/motor_model.sv
// Purpose: motor stand-in that returns a measured current sample
// Assumes: current in thousandths of rated current
// Notes: hold_en pins the sample; slow gives a lagging winding
`timescale 1ns/1ps
module motor_model #(
   parameter logic [15:0] INDUCTANCE = 16'h0123,
   parameter logic [15:0] RESISTANCE = 16'h0045
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic signed [15:0] motor_current_cmd,
   input wire logic slow,
   input wire logic hold_en,
   input wire logic signed [15:0] hold_value,
   output logic signed [15:0] measured_current,
   output logic [15:0] motor_inductance,
   output logic [15:0] motor_resistance
);
   logic signed [15:0] next_current; // next sample
   assign motor_inductance = INDUCTANCE; // winding constants
   assign motor_resistance = RESISTANCE;
   // sample follows the command at once, in steps, or is pinned
   always_comb begin
      next_current = motor_current_cmd;
      if (hold_en) begin
         next_current = hold_value;
      end else if (slow) begin
         next_current = measured_current
            + ((motor_current_cmd - measured_current) >>> 2);
      end
   end
   // sample kept in the unit of the command
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         measured_current <= 16'sh0000;
      end else begin
         measured_current <= next_current;
      end
   end
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench of the current-loop parameter block
// Assumes: filter sample period shortened to 8 cycles
// Notes: motor_model supplies winding values and measured current
`timescale 1ns/1ps
`include "current_loop_defines.svh"
module testbench;
   localparam int unsigned DIV = 8; // filter sample period
   localparam logic [15:0] LM = 16'h0123; // winding inductance
   localparam logic [15:0] RM = 16'h0045; // winding resistance
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic od_wr = 1'b0;
   logic od_rd = 1'b0;
   logic [15:0] od_index = 16'h0000;
   logic [7:0] od_sub = 8'h00;
   logic [31:0] od_wdata = 32'h0000_0000;
   logic [31:0] od_rdata;
   logic od_ack;
   logic od_err;
   logic [15:0] ind;
   logic [15:0] res;
   logic drive_enable = 1'b0;
   logic signed [15:0] current_cmd = 16'sh0000;
   logic signed [15:0] dynamic_amp_limit = 16'sh0000;
   logic signed [15:0] motor_current_cmd;
   logic signed [15:0] meas;
   logic signed [15:0] actual_current;
   logic [15:0] rec_sel; // record entries at the ports
   logic [15:0] rec_qkp;
   logic [15:0] rec_qki;
   logic [15:0] rec_dkp;
   logic [15:0] rec_dki;
   logic hold_en = 1'b0; // pins the motor sample
   logic signed [15:0] hold_value = 16'sh0000;
   logic [31:0] rd_q; // last answer of an access
   logic ack_q;
   logic err_q;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;

   current_loop_parameter_block #(.SAMPLE_DIV(DIV)) u_dut (
      .clk(clk), .reset_n(reset_n), .od_wr(od_wr), .od_rd(od_rd),
      .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata),
      .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
      .motor_inductance(ind), .motor_resistance(res),
      .drive_enable(drive_enable), .current_cmd(current_cmd),
      .dynamic_amp_limit(dynamic_amp_limit),
      .motor_current_cmd(motor_current_cmd), .measured_current(meas),
      .actual_current(actual_current),
      .loop_regulator_selector(rec_sel),
      .q_axis_proportional_gain(rec_qkp), .q_axis_integral_gain(rec_qki),
      .d_axis_proportional_gain(rec_dkp), .d_axis_integral_gain(rec_dki));

   motor_model #(.INDUCTANCE(LM), .RESISTANCE(RM)) u_motor (
      .clk(clk), .reset_n(reset_n), .motor_current_cmd(motor_current_cmd),
      .slow(1'b0), .hold_en(hold_en), .hold_value(hold_value),
      .measured_current(meas), .motor_inductance(ind),
      .motor_resistance(res));

   // free-running clock, 4 ns period
   always #2 clk = ~clk;

   // closing report, the one place the run ends
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one object access; request held over its taking edge
   task automatic acc(input logic w, input logic [15:0] ix,
                      input logic [7:0] sb, input logic [31:0] wd);
      int i;
      od_wr = w;
      od_rd = ~w;
      od_index = ix;
      od_sub = sb;
      od_wdata = wd;
      @(posedge clk);
      #1;
      od_wr = 1'b0;
      od_rd = 1'b0;
      i = 0;
      while (od_ack !== 1'b1 && od_err !== 1'b1 && i < 4) begin
         @(posedge clk);
         #1;
         i++;
      end
      ack_q = od_ack;
      err_q = od_err;
      rd_q = od_rdata;
      @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] wd, input logic e);
      acc(1'b1, ix, sb, wd);
      chk("write err", {31'h0, e}, {31'h0, err_q});
      chk("write ack", {31'h0, ~e}, {31'h0, ack_q});
   endtask

   task automatic rd(input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] x, input logic e);
      acc(1'b0, ix, sb, 32'h0);
      chk("read err", {31'h0, e}, {31'h0, err_q});
      chk("read ack", {31'h0, ~e}, {31'h0, ack_q});
      chk("read data", x, rd_q);
   endtask

   // command inputs set, then the two-stage path settles
   task automatic drive(input logic en, input logic signed [15:0] c,
                        input logic signed [15:0] lim);
      drive_enable = en;
      current_cmd = c;
      dynamic_amp_limit = lim;
      repeat (4) @(posedge clk);
      #1;
   endtask

   // record entry seen at the ports, by sub-index, zero-extended
   function automatic logic [31:0] rec(input int s);
      case (s)
         1: rec = {16'h0000, rec_sel};
         2: rec = {16'h0000, rec_qkp};
         3: rec = {16'h0000, rec_qki};
         4: rec = {16'h0000, rec_dkp};
         5: rec = {16'h0000, rec_dki};
         default: rec = 32'h0000_0000;
      endcase
   endfunction

   task automatic t_defaults();
      rd(`IDX_GAIN_RECORD, `SUB_COUNT, 32'h5, 1'b0);
      for (int s = 1; s <= 5; s++) begin
         rd(`IDX_GAIN_RECORD, 8'(s), 32'h0, 1'b0);
         chk("entry port", 32'h0, rec(s));
      end
      rd(`IDX_TORQUE_OFFSET, 8'h00, 32'h0, 1'b0);
      rd(`IDX_POST_OFFSET, 8'h00, 32'h0, 1'b0);
      rd(`IDX_FILTER_CUTOFF, 8'h00, 32'h0000_03e8, 1'b0);
      rd(`IDX_LOOP_CALC, 8'h00, 32'h0, 1'b0);
   endtask

   task automatic t_record();
      for (int s = 1; s <= 5; s++) begin
         wr(`IDX_GAIN_RECORD, 8'(s), 32'hffff_f000 | s, 1'b0);
      end
      for (int s = 1; s <= 5; s++) begin
         rd(`IDX_GAIN_RECORD, 8'(s), 32'h0000_f000 | s, 1'b0);
         chk("entry", 32'h0000_f000 | s, rec(s));
      end
      wr(`IDX_GAIN_RECORD, 8'h06, 32'h1, 1'b1);
      wr(`IDX_GAIN_RECORD, `SUB_COUNT, 32'h1, 1'b1);
      wr(`IDX_ACTUAL_CURRENT, 8'h00, 32'h1, 1'b1);
      rd(16'h1234, 8'h00, 32'h0, 1'b1);
      rd(`IDX_GAIN_RECORD, 8'h05, 32'h0000_f005, 1'b0);
   endtask

   task automatic t_calc();
      wr(`IDX_LOOP_CALC, 8'h00, 32'h636c_6164, 1'b0);
      rd(`IDX_GAIN_RECORD, `SUB_Q_KP, 32'h0000_f002, 1'b0);
      wr(`IDX_LOOP_CALC, 8'h00, `CALC_SIGNATURE, 1'b0);
      chk("q kp", {16'h0, LM}, rec(2));
      chk("q ki", {16'h0, RM}, rec(3));
      chk("d kp", {16'h0, LM}, rec(4));
      chk("d ki", {16'h0, RM}, rec(5));
      chk("selector", 32'h0000_f001, rec(1));
      rd(`IDX_GAIN_RECORD, `SUB_D_KI, {16'h0, RM}, 1'b0);
      rd(`IDX_LOOP_CALC, 8'h00, `CALC_SIGNATURE, 1'b0);
   endtask

   task automatic t_offsets();
      wr(`IDX_TORQUE_OFFSET, 8'h00, 32'h0000_0032, 1'b0);
      wr(`IDX_POST_OFFSET, 8'h00, 32'h0000_001e, 1'b0);
      drive(1'b1, 16'sd100, 16'sd120);
      chk("cmd", 32'h0096, {16'h0, motor_current_cmd});
      wr(`IDX_POST_OFFSET, 8'h00, 32'h0000_003c, 1'b0);
      chk("cmd", 32'h00b4, {16'h0, motor_current_cmd});
      current_cmd = 16'sd0;
      @(posedge clk);
      #1;
      chk("cmd held", 32'h00b4, {16'h0, motor_current_cmd});
      @(posedge clk);
      #1;
      chk("cmd new", 32'h006e, {16'h0, motor_current_cmd});
      drive(1'b1, -16'sd200, 16'sd120);
      chk("cmd neg", 32'hffc4, {16'h0, motor_current_cmd});
      // zero limit: only the second offset reaches the motor
      drive(1'b1, -16'sd50, 16'sd0);
      chk("cmd lim", 32'h003c, {16'h0, motor_current_cmd});
      drive(1'b0, 16'sd200, 16'sd120);
      chk("cmd off", 32'h0078, {16'h0, motor_current_cmd});
      drive(1'b0, 16'sd0, 16'sd120);
      chk("cmd idle", 32'h0000, {16'h0, motor_current_cmd});
      wr(`IDX_TORQUE_OFFSET, 8'h00, 32'h0000_fff6, 1'b0);
      rd(`IDX_TORQUE_OFFSET, 8'h00, 32'hffff_fff6, 1'b0);
   endtask

   task automatic t_filter();
      hold_value = -16'sd500;
      hold_en = 1'b1;
      wr(`IDX_FILTER_CUTOFF, 8'h00, 32'h0000_0bb8, 1'b0);
      repeat (4 * DIV) @(posedge clk);
      #1;
      chk("filtered", 32'hfe0c, {16'h0, actual_current});
      rd(`IDX_ACTUAL_CURRENT, 8'h00, 32'hffff_fe0c, 1'b0);
      wr(`IDX_FILTER_CUTOFF, 8'h00, 32'h0000_ffff, 1'b0);
      rd(`IDX_FILTER_CUTOFF, 8'h00, 32'hffff_ffff, 1'b0);
      hold_value = 16'sd200;
      repeat (4 * DIV) @(posedge clk);
      #1;
      chk("frozen", 32'hfe0c, {16'h0, actual_current});
   endtask

   // reset in mid-run: every object returns to its default
   task automatic t_reset();
      reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk("selector reset", 32'h0, rec(1));
      t_defaults();
   endtask

   // reset for 8 cycles, then the scenarios in turn
   initial begin
      repeat (8) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_defaults();
      t_record();
      t_calc();
      t_offsets();
      t_filter();
      t_reset();
      print_verdict();
   end
endmodule
